// ---- sdf_map.svh ----
`ifndef SDF_MAP_SVH
`define SDF_MAP_SVH
`define SDF_IDX_OFS 12'h000
`define SDF_ACC_OFS 12'h004
`define SDF_FLOOD_OFS 12'h008
`define SDF_IPMC_OFS 12'h00C
`define SDF_CTRL_OFS 12'h010
`define SDF_GRP_PAGE 4'h1
`define SDF_HOST_PORT 10
`define SDF_ALL_PORTS 11'h7FF
`define SDF_LAST_ENTRY 8'hFF
`define SDF_CMD_IDLE 2'h0
`define SDF_CMD_READ 2'h1
`define SDF_CMD_WRITE 2'h2
`define SDF_CMD_INIT 2'h3
`define SDF_MC4_LO 48'h0100_5E00_0000
`define SDF_MC4_HI 48'h0100_5E7F_FFFF
`define SDF_MC6_PFX 16'h3333
`define SDF_BCAST 48'hFFFF_FFFF_FFFF
`define SDF_V4_CTRL 24'hE0_0000
`define SDF_V6_CTRL 16'hFF02
`define SDF_GROUP_BIT 40
`endif

// ---- sdf_pkg.sv ----
package sdf_pkg;
	typedef enum logic [3:0] {
		SDF_ST_IDLE = 4'b0001,
		SDF_ST_READ = 4'b0010,
		SDF_ST_WRITE = 4'b0100,
		SDF_ST_INIT = 4'b1000
	} sdf_state_t;
	typedef enum logic [2:0] {
		SDF_FT_UC, SDF_FT_MC, SDF_FT_BC, SDF_FT_MC4C, SDF_FT_MC4D, SDF_FT_MC6C, SDF_FT_MC6D
	} sdf_flood_t;
	typedef struct packed {
		logic [10:0] service_forward_port_mask;
		logic [5:0] service_spanning_instance;
		logic service_egress_key_select;
		logic [7:0] service_policer_index;
	} sdf_entry_t;
	typedef struct packed {
		logic valid;
		logic [7:0] service_index;
		logic [11:0] vid;
		logic [47:0] dmac;
		logic is_ipv4;
		logic is_ipv6;
		logic is_igmp;
		logic [31:0] dip_hi;
		logic backbone_domain_select;
		logic learning_off_flag;
		logic [10:0] label_classifier_port_mask;
		logic [2:0] label_classifier_host_queue;
		logic basic_copy;
		logic basic_redirect;
		logic [2:0] basic_queue;
		logic action_host_copy_enable;
		logic [2:0] action_host_queue_number;
		logic action_discard_enable;
	} sdf_req_t;
	typedef struct packed {
		logic hit;
		logic backbone_domain_flag;
		logic [1:0] entry_type;
		logic [5:0] group_index;
		logic entry_host_copy_flag;
	} sdf_mac_t;
	typedef struct packed {
		logic valid;
		logic [10:0] forward_port_set;
		logic [7:0] host_queue_mask;
		logic learning_off_flag;
		logic flooded;
		logic egress_key_is_service;
		logic [11:0] egress_key;
		logic [5:0] service_spanning_instance;
		logic [7:0] service_policer_index;
	} sdf_res_t;
endpackage : sdf_pkg

// ---- sdf_analyzer.sv ----
`timescale 1ns/100ps
`include "sdf_map.svh"
module sdf_analyzer (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire sdf_pkg::sdf_req_t req,
	input wire sdf_pkg::sdf_mac_t mac,
	output sdf_pkg::sdf_res_t res
);
	import sdf_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [7:0] qbit(input logic [2:0] q);
		return 8'h01 << q;
	endfunction : qbit

	function automatic sdf_flood_t classify(input sdf_req_t r);
		logic mc4;
		logic mc6;
		mc4 = r.dmac >= `SDF_MC4_LO && r.dmac <= `SDF_MC4_HI && r.is_ipv4 && !r.is_igmp;
		mc6 = r.dmac[47:32] == `SDF_MC6_PFX && r.is_ipv6;
		if (r.dmac == `SDF_BCAST) begin
			return SDF_FT_BC;
		end else if (mc4) begin
			return (r.dip_hi[31:8] == `SDF_V4_CTRL) ? SDF_FT_MC4C : SDF_FT_MC4D;
		end else if (mc6) begin
			return (r.dip_hi[31:16] == `SDF_V6_CTRL) ? SDF_FT_MC6C : SDF_FT_MC6D;
		end else if (r.dmac[`SDF_GROUP_BIT]) begin
			return SDF_FT_MC;
		end
		return SDF_FT_UC;
	endfunction : classify

	// ==========================================================
	// Storage
	sdf_entry_t svc_mem [256];
	logic [14:0] grp_mem [64];

	sdf_state_t state_reg;
	logic [7:0] cnt_reg;
	logic [7:0] sel_reg;
	logic [5:0] msti_reg;
	logic key_reg;
	logic [7:0] pol_reg;
	logic [10:0] mask_reg;
	logic [31:0] flood_reg;
	logic [31:0] ipmc_reg;
	logic skip_reg;
	logic [2:0] macq_reg;

	// ==========================================================
	// AXI4-Lite write path
	logic aw_hold_reg;
	logic [11:0] aw_addr_reg;
	logic w_hold_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;

	wire do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
	wire wr_grp = aw_addr_reg[11:8] == `SDF_GRP_PAGE;
	wire wr_idx = aw_addr_reg == `SDF_IDX_OFS;
	wire wr_acc = aw_addr_reg == `SDF_ACC_OFS;
	wire wr_fld = aw_addr_reg == `SDF_FLOOD_OFS;
	wire wr_ipmc = aw_addr_reg == `SDF_IPMC_OFS;
	wire wr_ctl = aw_addr_reg == `SDF_CTRL_OFS;
	wire wr_ok = wr_grp || wr_idx || wr_acc || wr_fld || wr_ipmc || wr_ctl;
	wire idle = state_reg == SDF_ST_IDLE;

	logic [31:0] idx_word;
	logic [31:0] acc_word;
	logic [1:0] cmd_now;
	assign cmd_now = (state_reg == SDF_ST_READ) ? `SDF_CMD_READ :
		(state_reg == SDF_ST_WRITE) ? `SDF_CMD_WRITE :
		(state_reg == SDF_ST_INIT) ? `SDF_CMD_INIT : `SDF_CMD_IDLE;
	assign idx_word = {pol_reg, 2'h0, msti_reg, 7'h00, key_reg, sel_reg};
	assign acc_word = {19'h0_0000, mask_reg, cmd_now};

	wire [31:0] idx_new = merge(idx_word, w_data_reg, w_strb_reg);
	wire [31:0] acc_new = merge(acc_word, w_data_reg, w_strb_reg);
	wire [31:0] grp_old = {17'h0_0000, grp_mem[aw_addr_reg[7:2]]};
	wire [31:0] grp_new = merge(grp_old, w_data_reg, w_strb_reg);
	// Table registers are frozen while a command runs
	wire idx_we = do_wr && wr_idx && idle;
	wire acc_we = do_wr && wr_acc && idle;
	wire [1:0] cmd_in = acc_new[1:0];

	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready = !w_hold_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_reg <= 1'b1;
			aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
		end else if (do_wr) begin
			aw_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			w_hold_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (do_wr) begin
			w_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'b00;
		end else if (do_wr) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_ok ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
	wire rd_grp = ra[11:8] == `SDF_GRP_PAGE;
	wire [31:0] rd_word = rd_grp ? {17'h0_0000, grp_mem[ra[7:2]]} :
		(ra == `SDF_IDX_OFS) ? idx_word :
		(ra == `SDF_ACC_OFS) ? acc_word :
		(ra == `SDF_FLOOD_OFS) ? flood_reg :
		(ra == `SDF_IPMC_OFS) ? ipmc_reg :
		(ra == `SDF_CTRL_OFS) ? {21'h00_0000, macq_reg, 7'h00, skip_reg} : 32'h0000_0000;
	wire rd_ok = rd_grp || ra == `SDF_IDX_OFS || ra == `SDF_ACC_OFS ||
		ra == `SDF_FLOOD_OFS || ra == `SDF_IPMC_OFS || ra == `SDF_CTRL_OFS;

	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_ok ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flood_reg <= 32'h0000_0000;
			ipmc_reg <= 32'h0000_0000;
			skip_reg <= 1'b0;
			macq_reg <= 3'h0;
		end else if (do_wr) begin
			if (wr_fld) begin
				flood_reg <= merge(flood_reg, w_data_reg, w_strb_reg) & 32'h003F_3F3F;
			end
			if (wr_ipmc) begin
				ipmc_reg <= merge(ipmc_reg, w_data_reg, w_strb_reg) & 32'h3F3F_3F3F;
			end
			if (wr_ctl && w_strb_reg[0]) begin
				skip_reg <= w_data_reg[0];
			end
			if (wr_ctl && w_strb_reg[1]) begin
				macq_reg <= w_data_reg[10:8];
			end
		end
	end

	// Group table resets empty; software must fill it before traffic
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 64; i++) begin
				grp_mem[i] <= 15'h0000;
			end
		end else if (do_wr && wr_grp) begin
			grp_mem[aw_addr_reg[7:2]] <= {grp_new[14:12], 1'b0, grp_new[10:0]};
		end
	end

	// ==========================================================
	// Service table command engine
	logic mem_we;
	logic [7:0] mem_wa;
	sdf_entry_t mem_wd;
	sdf_entry_t rd_entry;
	sdf_state_t state_next;

	assign rd_entry = svc_mem[sel_reg];
	assign mem_we = (state_reg == SDF_ST_INIT) || (state_reg == SDF_ST_WRITE);
	assign mem_wa = (state_reg == SDF_ST_INIT) ? cnt_reg : sel_reg;
	assign mem_wd = (state_reg == SDF_ST_INIT) ?
		sdf_entry_t'({`SDF_ALL_PORTS, 15'h0000}) :
		sdf_entry_t'({mask_reg, msti_reg, key_reg, pol_reg});

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SDF_ST_IDLE: begin
				if (acc_we) begin
					unique case (cmd_in)
						`SDF_CMD_READ: state_next = SDF_ST_READ;
						`SDF_CMD_WRITE: state_next = SDF_ST_WRITE;
						`SDF_CMD_INIT: state_next = SDF_ST_INIT;
						`SDF_CMD_IDLE: state_next = SDF_ST_IDLE;
					endcase
				end
			end
			SDF_ST_READ: state_next = SDF_ST_IDLE;
			SDF_ST_WRITE: state_next = SDF_ST_IDLE;
			SDF_ST_INIT: begin
				if (cnt_reg == `SDF_LAST_ENTRY) begin
					state_next = SDF_ST_IDLE;
				end
			end
			default: state_next = SDF_ST_IDLE;
		endcase
	end

	// Table initialises itself after reset, so it starts at the default
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= SDF_ST_INIT;
			cnt_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg <= (state_reg == SDF_ST_INIT) ? cnt_reg + 8'h01 : 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (mem_we) begin
			svc_mem[mem_wa] <= mem_wd;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_reg <= 8'h00;
			key_reg <= 1'b0;
			msti_reg <= 6'h00;
			pol_reg <= 8'h00;
		end else if (state_reg == SDF_ST_READ) begin
			key_reg <= rd_entry.service_egress_key_select;
			msti_reg <= rd_entry.service_spanning_instance;
			pol_reg <= rd_entry.service_policer_index;
		end else if (idx_we) begin
			sel_reg <= idx_new[7:0];
			key_reg <= idx_new[8];
			msti_reg <= idx_new[21:16];
			pol_reg <= idx_new[31:24];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_reg <= 11'h000;
		end else if (state_reg == SDF_ST_READ) begin
			mask_reg <= rd_entry.service_forward_port_mask;
		end else if (acc_we) begin
			mask_reg <= acc_new[12:2];
		end
	end

	// ==========================================================
	// Destination analysis, one combinational pass per request
	sdf_entry_t svc;
	sdf_flood_t ft;
	logic hit;
	logic [5:0] flood_idx;
	logic [5:0] grp_i;
	logic [14:0] grp_w;
	logic [7:0] q_grp;
	logic [7:0] q_mac;
	logic [7:0] q_cls;
	logic [7:0] q_act;
	logic kill;
	sdf_res_t res_next;

	assign svc = svc_mem[req.service_index];
	assign hit = mac.hit && (mac.backbone_domain_flag == req.backbone_domain_select);
	assign ft = classify(req);
	assign flood_idx = (ft == SDF_FT_UC) ? flood_reg[5:0] :
		(ft == SDF_FT_MC) ? flood_reg[13:8] :
		(ft == SDF_FT_BC) ? flood_reg[21:16] :
		(ft == SDF_FT_MC4C) ? ipmc_reg[5:0] :
		(ft == SDF_FT_MC4D) ? ipmc_reg[13:8] :
		(ft == SDF_FT_MC6C) ? ipmc_reg[21:16] : ipmc_reg[29:24];
	assign grp_i = hit ? mac.group_index : flood_idx;
	assign grp_w = grp_mem[grp_i];
	assign q_grp = (hit && !mac.entry_type[1] && grp_w[`SDF_HOST_PORT]) ?
		qbit(grp_w[14:12]) : 8'h00;
	assign q_mac = (hit && mac.entry_host_copy_flag && !skip_reg) ?
		qbit(macq_reg) : 8'h00;
	assign q_cls = (req.label_classifier_port_mask[`SDF_HOST_PORT] ?
		qbit(req.label_classifier_host_queue) : 8'h00) |
		((req.basic_copy || req.basic_redirect) ? qbit(req.basic_queue) : 8'h00);
	assign q_act = req.action_host_copy_enable ?
		qbit(req.action_host_queue_number) : 8'h00;
	assign kill = req.basic_redirect || req.action_discard_enable;

	always_comb begin
		res_next = '0;
		res_next.valid = req.valid;
		// Steps apply in order: lookup, flood, kills, host copies
		res_next.forward_port_set = kill ? 11'h000 : grp_w[10:0];
		res_next.forward_port_set[`SDF_HOST_PORT] = 1'b0;
		res_next.host_queue_mask = q_grp | q_mac | q_cls | q_act;
		res_next.learning_off_flag = req.learning_off_flag;
		res_next.flooded = !hit;
		res_next.egress_key_is_service = svc.service_egress_key_select;
		res_next.egress_key = svc.service_egress_key_select ?
			{4'h0, req.service_index} : req.vid;
		res_next.service_spanning_instance = svc.service_spanning_instance;
		res_next.service_policer_index = svc.service_policer_index;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			res <= '0;
		end else begin
			res <= res_next;
		end
	end
endmodule : sdf_analyzer

// ---- sdf_checker.sv ----
`timescale 1ns/100ps
// ====================
// Result and bus checks
module sdf_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire sdf_pkg::sdf_req_t req,
	input wire sdf_pkg::sdf_mac_t mac,
	input wire sdf_pkg::sdf_res_t res
);
	import sdf_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Hit only counts in the searched domain
	wire hit_eff = mac.hit && (mac.backbone_domain_flag == req.backbone_domain_select);
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	chk_host_port_out: assert property (res.forward_port_set[10] == 1'b0)
		else $error("host port in port set");
	chk_res_valid: assert property (res.valid == $past(req.valid))
		else $error("result valid not one cycle after request");
	chk_learn_copy: assert property (
		req.valid |=> res.learning_off_flag == $past(req.learning_off_flag))
		else $error("learning flag lost");
	chk_flood_miss: assert property (req.valid |=> res.flooded == !$past(hit_eff))
		else $error("flood decision wrong");
	chk_kill_clear: assert property (
		req.valid && (req.basic_redirect || req.action_discard_enable) |=> res.forward_port_set == '0)
		else $error("port set not cleared");
	chk_label_queue: assert property (
		req.valid && req.label_classifier_port_mask[10]
		|=> res.host_queue_mask[$past(req.label_classifier_host_queue)])
		else $error("label queue missing");
	chk_basic_queue: assert property (
		req.valid && (req.basic_copy || req.basic_redirect)
		|=> res.host_queue_mask[$past(req.basic_queue)])
		else $error("basic queue missing");
	chk_action_queue: assert property (
		req.valid && req.action_host_copy_enable
		|=> res.host_queue_mask[$past(req.action_host_queue_number)])
		else $error("action queue missing");
	chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	chk_resp_hold: assert property (s_b_wait |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule : sdf_checker
bind sdf_analyzer sdf_checker u_chk (.clk, .arst_n, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .req, .mac, .res);

// ---- sdf_req_src.sv ----
`timescale 1ns/100ps
// ====================
// Request source for port and classifier stages
module sdf_req_src (
	input wire logic clk,
	output sdf_pkg::sdf_req_t req,
	output sdf_pkg::sdf_mac_t mac
);
	import sdf_pkg::*;
	sdf_req_t idle_r;
	initial begin
		req = '0;
		mac = '0;
	end
	// Idle cycles carry inverted junk so stale fields are never trusted
	task send(input sdf_req_t r, input sdf_mac_t m);
		@(posedge clk);
		req <= r;
		mac <= m;
		@(posedge clk);
		idle_r = ~r;
		idle_r.valid = 1'b0;
		req <= idle_r;
		mac <= ~m;
	endtask : send
endmodule : sdf_req_src

// ---- tb_top.sv ----
`timescale 1ns/100ps
`include "sdf_map.svh"
module tb_top;
	import sdf_pkg::*;
	typedef struct packed {
		logic [47:0] dmac;
		logic [2:0] pr;
		logic [31:0] dip;
		logic [3:0] mt;
		logic [10:0] ps;
		logic [7:0] qm;
	} sdf_tb_row_t;
	logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	sdf_req_t req, r;
	sdf_mac_t mac, m;
	sdf_res_t res;
	int miscompares, num_checks;
	sdf_tb_row_t rows [12] = '{
		'{48'h0000_0000_0001, 3'h0, 32'h0, 4'h0, 11'h001, 8'h00},
		'{48'h0100_0000_0000, 3'h0, 32'h0, 4'h0, 11'h002, 8'h00},
		'{48'hFFFF_FFFF_FFFF, 3'h0, 32'h0, 4'h0, 11'h003, 8'h00},
		'{48'h0100_5E00_0001, 3'h4, 32'hE000_0005, 4'h0, 11'h004, 8'h00},
		'{48'h0100_5E7F_FFFF, 3'h4, 32'hE000_0100, 4'h0, 11'h005, 8'h00},
		'{48'h3333_0000_0001, 3'h2, 32'hFF02_0000, 4'h0, 11'h006, 8'h00},
		'{48'h3333_FFFF_FFFF, 3'h2, 32'hFF05_0000, 4'h0, 11'h007, 8'h00},
		'{48'h0100_5E00_0001, 3'h5, 32'hE000_0005, 4'h0, 11'h002, 8'h00},
		'{48'h0100_5E80_0000, 3'h4, 32'hE000_0005, 4'h0, 11'h002, 8'h00},
		'{48'h0000_0000_0001, 3'h0, 32'h0, 4'h8, 11'h0F0, 8'h20},
		'{48'h0000_0000_0001, 3'h0, 32'h0, 4'hC, 11'h001, 8'h00},
		'{48'h0000_0000_0001, 3'h0, 32'h0, 4'hA, 11'h0F0, 8'h00}};

	sdf_analyzer DUT (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req, .mac, .res);
	sdf_req_src u_src (.clk, .req, .mac);

	always #5 clk = ~clk;

	// ====================
	// Bus and check tasks
	task chk(input logic [47:0] seen, input logic [47:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [31:0] wd, input logic [1:0] er = 2'h0,
		input logic [3:0] st = 4'hF);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			aw_ok |= s_axi_awvalid && s_axi_awready;
			w_ok |= s_axi_wvalid && s_axi_wready;
			s_axi_awvalid <= !aw_ok;
			s_axi_wvalid <= !w_ok;
		end
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask : wr
	task rd(input logic [11:0] a, output logic [31:0] rd_d, output logic [1:0] rd_r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
	endtask : rd
	// Commands only start from idle
	task poll;
		do rd(`SDF_ACC_OFS, d, rs); while (d[1:0] !== `SDF_CMD_IDLE);
	endtask : poll
	task go(input sdf_req_t gr, input sdf_mac_t gm);
		u_src.send(gr, gm);
		#1;
	endtask : go
	task complete_run;
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	// ====================
	// Sequence
	initial begin
		clk = 0;
		arst_n = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		miscompares = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rd(`SDF_ACC_OFS, d, rs);
		chk(d[1:0], `SDF_CMD_INIT);
		poll;
		wr(`SDF_IDX_OFS, 32'h0000_0005);
		wr(`SDF_ACC_OFS, 32'h0000_0001);
		poll;
		rd(`SDF_ACC_OFS, d, rs);
		chk(d, 32'h0000_1FFC);
		rd(`SDF_IDX_OFS, d, rs);
		chk(d, 32'h0000_0005);
		$display("test reset_init done");
		wr(`SDF_FLOOD_OFS, 32'h0003_0201);
		wr(`SDF_IPMC_OFS, 32'h0706_0504);
		wr(`SDF_CTRL_OFS, 32'h0000_0300);
		for (int i = 1; i < 8; i++) wr(12'h100 + 12'(4 * i), 32'(i * 4097));
		wr(12'h120, 32'h0000_5CF0);
		rd(12'h120, d, rs);
		chk(d, 32'h0000_54F0);
		wr(12'h020, 32'h1234_5678, 2'h2);
		rd(12'h020, d, rs);
		chk({rs, d}, {2'h2, 32'h0});
		$display("test config done");
		foreach (rows[i]) begin
			r = '0;
			r.valid = 1'b1;
			r.dmac = rows[i].dmac;
			{r.is_ipv4, r.is_ipv6, r.is_igmp} = rows[i].pr;
			r.dip_hi = rows[i].dip;
			r.learning_off_flag = i[0];
			m = '0;
			{m.hit, m.backbone_domain_flag, m.entry_type} = rows[i].mt;
			m.group_index = 6'd8;
			go(r, m);
			chk(res.forward_port_set, rows[i].ps);
			chk(res.host_queue_mask, rows[i].qm);
			chk({res.valid, res.learning_off_flag}, {1'b1, i[0]});
			chk(res.flooded, !(rows[i].mt[3] && !rows[i].mt[2]));
		end
		$display("test rows done");
		// Entry 9 gets every field distinct so swapped slices show up
		wr(`SDF_IDX_OFS, 32'hA52A_0109);
		wr(`SDF_ACC_OFS, 32'h0000_0556);
		poll;
		wr(`SDF_IDX_OFS, 32'h0000_0009);
		wr(`SDF_ACC_OFS, 32'h0000_0001);
		poll;
		rd(`SDF_ACC_OFS, d, rs);
		chk(d, 32'h0000_0554);
		rd(`SDF_IDX_OFS, d, rs);
		chk(d, 32'hA52A_0109);
		r = '0;
		r.valid = 1'b1;
		r.service_index = 8'h09;
		r.vid = 12'h123;
		m = '0;
		go(r, m);
		chk({res.egress_key_is_service, res.egress_key}, 13'h1009);
		chk({res.service_spanning_instance, res.service_policer_index}, 14'h2AA5);
		r.service_index = 8'h05;
		go(r, m);
		chk({res.egress_key_is_service, res.egress_key}, 13'h0123);
		wr(`SDF_ACC_OFS, 32'h0000_0003);
		poll;
		wr(`SDF_ACC_OFS, 32'h0000_0001);
		poll;
		rd(`SDF_ACC_OFS, d, rs);
		chk(d, 32'h0000_1FFC);
		rd(`SDF_IDX_OFS, d, rs);
		chk(d, 32'h0000_0009);
		$display("test service_table done");
		r = '0;
		r.valid = 1'b1;
		r.dmac = 48'h0000_0000_0001;
		m.hit = 1'b1;
		m.group_index = 6'd8;
		m.entry_host_copy_flag = 1'b1;
		go(r, m);
		chk(res.host_queue_mask, 8'h28);
		wr(`SDF_CTRL_OFS, 32'h0000_0301);
		go(r, m);
		chk(res.host_queue_mask, 8'h20);
		r.label_classifier_port_mask = 11'h400;
		r.label_classifier_host_queue = 3'd1;
		go(r, m);
		chk(res.host_queue_mask, 8'h22);
		r.basic_copy = 1'b1;
		r.basic_queue = 3'd2;
		go(r, m);
		chk({res.forward_port_set, res.host_queue_mask}, {11'h0F0, 8'h26});
		r.basic_copy = 1'b0;
		r.basic_redirect = 1'b1;
		r.basic_queue = 3'd4;
		go(r, m);
		chk({res.forward_port_set, res.host_queue_mask}, {11'h000, 8'h32});
		r.basic_redirect = 1'b0;
		r.action_host_copy_enable = 1'b1;
		r.action_host_queue_number = 3'd6;
		go(r, m);
		chk({res.forward_port_set, res.host_queue_mask}, {11'h0F0, 8'h62});
		r.action_discard_enable = 1'b1;
		go(r, m);
		chk({res.forward_port_set, res.host_queue_mask}, {11'h000, 8'h62});
		$display("test host_queues done");
		// Backbone search only matches backbone entries
		r = '0;
		r.valid = 1'b1;
		r.dmac = 48'h0000_0000_0001;
		r.backbone_domain_select = 1'b1;
		m = '0;
		m.hit = 1'b1;
		m.backbone_domain_flag = 1'b1;
		m.group_index = 6'd8;
		go(r, m);
		chk({res.flooded, res.forward_port_set}, {1'b0, 11'h0F0});
		m.backbone_domain_flag = 1'b0;
		go(r, m);
		chk({res.flooded, res.forward_port_set}, {1'b1, 11'h001});
		// Single byte lane leaves the other flood indexes alone
		wr(`SDF_FLOOD_OFS, 32'hFFFF_09FF, 2'h0, 4'h2);
		rd(`SDF_FLOOD_OFS, d, rs);
		chk(d, 32'h0003_0901);
		wr(`SDF_ACC_OFS, 32'h0000_0004);
		rd(`SDF_ACC_OFS, d, rs);
		chk(d, 32'h0000_0004);
		$display("test domain_strobe done");
		complete_run;
	end

	// Generous bound: the sequence needs well under a thousand cycles
	initial begin
		#200000;
		miscompares++;
		$display("test watchdog expired");
		complete_run;
	end
endmodule : tb_top
